// [ncpo_apb_host.sv]
// APB master model that stands for the configuration tool on the far side.
`timescale 1ns/1ps
`default_nettype none
module ncpo_apb_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [17:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h00000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
  end

  // A released bus shows inverted values so that nothing stale can pass for a match.
  task automatic xfer(input logic w, input logic [17:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// [ncpo_pkg.sv]
// Package with register map, field layout and reset values of the network configuration bank.
package ncpo_pkg;
  // Object indices; the APB byte address is four times the index.
  localparam logic [15:0] IDX_PROG_CTRL = 16'h1f51;
  localparam logic [15:0] IDX_PROG_STAT = 16'h1f57;
  localparam logic [15:0] IDX_HW_ADDR = 16'h200f;
  localparam logic [15:0] IDX_NET_CFG = 16'h2010;
  localparam logic [15:0] IDX_STATIC_ADDR = 16'h2011;
  localparam logic [15:0] IDX_STATIC_MASK = 16'h2012;
  localparam logic [17:0] ADDR_PROG_CTRL = {IDX_PROG_CTRL, 2'b00};
  localparam logic [17:0] ADDR_PROG_STAT = {IDX_PROG_STAT, 2'b00};
  localparam logic [17:0] ADDR_HW_ADDR_LO = {IDX_HW_ADDR, 2'b00};
  localparam logic [17:0] ADDR_NET_CFG = {IDX_NET_CFG, 2'b00};
  localparam logic [17:0] ADDR_STATIC_ADDR = {IDX_STATIC_ADDR, 2'b00};
  localparam logic [17:0] ADDR_STATIC_MASK = {IDX_STATIC_MASK, 2'b00};
  localparam logic [17:0] ADDR_STAT_FW = 18'h00100;
  localparam logic [17:0] ADDR_STAT_USER = 18'h00104;
  localparam logic [17:0] ADDR_HW_ADDR_HI = 18'h00108;
  localparam logic [17:0] ADDR_RESTART = 18'h0010c;
  localparam logic [17:0] ADDR_ACTIVE = 18'h00110;
  // Field layout of the network configuration word.
  localparam int BIT_STATIC = 0;
  localparam int BIT_DHCP = 2;
  localparam int BIT_AUTO = 3;
  localparam int BIT_NAME_SVC = 5;
  localparam int BIT_MCAST_RES = 6;
  localparam logic [31:0] NET_CFG_WMASK = 32'h0000006d;
  // Reset values.
  localparam logic [7:0] ENTRY_COUNT = 8'h02;
  localparam logic [7:0] PROG_CTRL_RST = 8'h00;
  localparam logic [31:0] PROG_STAT_RST = 32'h00000000;
  localparam logic [47:0] HW_ADDR_RST = 48'h000000000000;
  localparam logic [31:0] NET_CFG_RST = 32'h0000006c;
  localparam logic [31:0] STATIC_ADDR_RST = 32'hc0a80792;
  localparam logic [31:0] STATIC_MASK_RST = 32'h0fffff00;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;

  // Address assignment and name resolution in force since the last restart.
  typedef struct packed {
    logic static_enable;
    logic dhcp_enable;
    logic auto_enable;
    logic name_service_enable;
    logic multicast_name_resolution_enable;
    logic [31:0] address;
    logic [31:0] mask;
  } ncpo_net_active_t;
endpackage

// [ncpo_regs.sv]
// APB register bank for program control/status and network configuration.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Program control reports two entries and holds two writable bytes, firmware and user program, reset to zero.
// - Program status shows two read-only 32-bit progress words, firmware and user program, reset to zero.
// - The hardware address is a read-only string, not saved, reset to zero.
// - The network word is taken into use only at a restart; later writes wait for the next restart.
// - Bit 0 set selects the stored static address together with the stored mask.
// - Bit 2 set enables address assignment by a DHCP server.
// - Bit 3 set enables automatic link-local address assignment.
// - Bit 5 set enables the name service needed for hostname resolution.
// - Bit 6 set enables link-local multicast name resolution.
// - The network word is read/write and resets to 0000006c.
// - The static address holds four bytes, first in bits 31:24, read/write, reset c0a80792.
// - The static mask holds four bytes in the same order, read/write, reset 0fffff00.
module ncpo_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] status_firmware_in,
  input wire logic [31:0] status_user_program_in,
  input wire logic [47:0] hw_address_in,
  output logic [7:0] control_firmware,
  output logic [7:0] control_user_program,
  output ncpo_pkg::ncpo_net_active_t net_active,
  output logic net_active_valid
);

  // --------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic hit;
  logic [31:0] byte_mask;
  logic [31:0] rdata_mux;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  always_comb begin
    case (paddr)
      ncpo_pkg::ADDR_PROG_CTRL,
      ncpo_pkg::ADDR_PROG_STAT,
      ncpo_pkg::ADDR_HW_ADDR_LO,
      ncpo_pkg::ADDR_NET_CFG,
      ncpo_pkg::ADDR_STATIC_ADDR,
      ncpo_pkg::ADDR_STATIC_MASK,
      ncpo_pkg::ADDR_STAT_FW,
      ncpo_pkg::ADDR_STAT_USER,
      ncpo_pkg::ADDR_HW_ADDR_HI,
      ncpo_pkg::ADDR_RESTART,
      ncpo_pkg::ADDR_ACTIVE: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~hit;

  // --------------------------------------------------------------
  // Program control and status
  // --------------------------------------------------------------
  logic [31:0] status_firmware;
  logic [31:0] status_user_program;
  logic [47:0] hw_address;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_firmware <= ncpo_pkg::PROG_CTRL_RST;
      control_user_program <= ncpo_pkg::PROG_CTRL_RST;
    end else if (wr_en && paddr == ncpo_pkg::ADDR_PROG_CTRL) begin
      if (pstrb[1]) begin
        control_firmware <= pwdata[15:8];
      end
      if (pstrb[2]) begin
        control_user_program <= pwdata[23:16];
      end
    end
  end

  // Status words and the hardware address follow the programming logic; software cannot write them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_firmware <= ncpo_pkg::PROG_STAT_RST;
      status_user_program <= ncpo_pkg::PROG_STAT_RST;
      hw_address <= ncpo_pkg::HW_ADDR_RST;
    end else begin
      status_firmware <= status_firmware_in;
      status_user_program <= status_user_program_in;
      hw_address <= hw_address_in;
    end
  end

  // --------------------------------------------------------------
  // Network configuration words
  // --------------------------------------------------------------
  logic [31:0] net_cfg;
  logic [31:0] static_addr;
  logic [31:0] static_mask;
  logic [31:0] cfg_mask;

  assign cfg_mask = byte_mask & ncpo_pkg::NET_CFG_WMASK;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      net_cfg <= ncpo_pkg::NET_CFG_RST;
    end else if (wr_en && paddr == ncpo_pkg::ADDR_NET_CFG) begin
      // Unassigned bits stay zero whatever is written.
      net_cfg <= (net_cfg & ~cfg_mask) | (pwdata & cfg_mask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      static_addr <= ncpo_pkg::STATIC_ADDR_RST;
    end else if (wr_en && paddr == ncpo_pkg::ADDR_STATIC_ADDR) begin
      static_addr <= (static_addr & ~byte_mask) | (pwdata & byte_mask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      static_mask <= ncpo_pkg::STATIC_MASK_RST;
    end else if (wr_en && paddr == ncpo_pkg::ADDR_STATIC_MASK) begin
      static_mask <= (static_mask & ~byte_mask) | (pwdata & byte_mask);
    end
  end

  // --------------------------------------------------------------
  // Restart capture
  // --------------------------------------------------------------
  // A restart is the release of reset or a write of bit 0 to the restart register.
  logic capture_pending;
  logic restart_write;

  assign restart_write = wr_en && paddr == ncpo_pkg::ADDR_RESTART && pstrb[0] && pwdata[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_pending <= 1'b1;
    end else begin
      capture_pending <= restart_write;
    end
  end

  // The live words are sampled once per restart; writes in between stay dormant.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      net_active <= '0;
      net_active_valid <= 1'b0;
    end else if (capture_pending) begin
      net_active.static_enable <= net_cfg[ncpo_pkg::BIT_STATIC];
      net_active.dhcp_enable <= net_cfg[ncpo_pkg::BIT_DHCP];
      net_active.auto_enable <= net_cfg[ncpo_pkg::BIT_AUTO];
      net_active.name_service_enable <= net_cfg[ncpo_pkg::BIT_NAME_SVC];
      net_active.multicast_name_resolution_enable <= net_cfg[ncpo_pkg::BIT_MCAST_RES];
      // Static address and mask only apply when static assignment is chosen.
      net_active.address <= net_cfg[ncpo_pkg::BIT_STATIC] ? static_addr : ncpo_pkg::ZERO_WORD;
      net_active.mask <= net_cfg[ncpo_pkg::BIT_STATIC] ? static_mask : ncpo_pkg::ZERO_WORD;
      net_active_valid <= 1'b1;
    end
  end

  // --------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------
  always_comb begin
    case (paddr)
      ncpo_pkg::ADDR_PROG_CTRL: rdata_mux = {8'h00, control_user_program, control_firmware, ncpo_pkg::ENTRY_COUNT};
      ncpo_pkg::ADDR_PROG_STAT: rdata_mux = {24'h000000, ncpo_pkg::ENTRY_COUNT};
      ncpo_pkg::ADDR_STAT_FW: rdata_mux = status_firmware;
      ncpo_pkg::ADDR_STAT_USER: rdata_mux = status_user_program;
      ncpo_pkg::ADDR_HW_ADDR_LO: rdata_mux = hw_address[31:0];
      ncpo_pkg::ADDR_HW_ADDR_HI: rdata_mux = {16'h0000, hw_address[47:32]};
      ncpo_pkg::ADDR_NET_CFG: rdata_mux = net_cfg;
      ncpo_pkg::ADDR_STATIC_ADDR: rdata_mux = static_addr;
      ncpo_pkg::ADDR_STATIC_MASK: rdata_mux = static_mask;
      ncpo_pkg::ADDR_ACTIVE: rdata_mux = {26'h0000000, net_active_valid,
                                          net_active.multicast_name_resolution_enable,
                                          net_active.name_service_enable, net_active.auto_enable,
                                          net_active.dhcp_enable, net_active.static_enable};
      default: rdata_mux = ncpo_pkg::ZERO_WORD;
    endcase
  end

  // Read data is registered in the setup cycle so it stands during the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= ncpo_pkg::ZERO_WORD;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_mux;
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  sequence s_restart_req;
    restart_write;
  endsequence

  sequence s_capture;
    ##1 capture_pending ##1 net_active_valid;
  endsequence

  a_restart_takes_cfg: assert property (@(posedge pclk) disable iff (!presetn)
    s_restart_req |-> ##2 net_active.dhcp_enable == $past(net_cfg[ncpo_pkg::BIT_DHCP], 1))
    else $error("active DHCP bit not taken at restart");

  a_restart_sequence: assert property (@(posedge pclk) disable iff (!presetn)
    s_restart_req |-> s_capture)
    else $error("restart did not capture configuration");

  a_active_holds_still: assert property (@(posedge pclk) disable iff (!presetn)
    !capture_pending |=> $stable(net_active))
    else $error("active configuration changed without restart");

  a_static_addr_used: assert property (@(posedge pclk) disable iff (!presetn)
    capture_pending && net_cfg[ncpo_pkg::BIT_STATIC] |=> net_active.address == $past(static_addr)
      && net_active.mask == $past(static_mask))
    else $error("static address or mask not applied");

  a_name_flags_follow: assert property (@(posedge pclk) disable iff (!presetn)
    capture_pending |=> net_active.name_service_enable == $past(net_cfg[ncpo_pkg::BIT_NAME_SVC])
      && net_active.multicast_name_resolution_enable == $past(net_cfg[ncpo_pkg::BIT_MCAST_RES]))
    else $error("name resolution enables wrong");

  a_auto_flag_follows: assert property (@(posedge pclk) disable iff (!presetn)
    capture_pending |=> net_active.auto_enable == $past(net_cfg[ncpo_pkg::BIT_AUTO]))
    else $error("automatic assignment enable wrong");

  a_cfg_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (net_cfg & ~ncpo_pkg::NET_CFG_WMASK) == ncpo_pkg::ZERO_WORD)
    else $error("unassigned network bits set");

  a_status_read_only: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == ncpo_pkg::ADDR_STAT_FW |=> status_firmware == $past(status_firmware_in))
    else $error("status word taken from bus");

  a_ctrl_write_byte: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == ncpo_pkg::ADDR_PROG_CTRL && pstrb[1] |=> control_firmware == $past(pwdata[15:8]))
    else $error("firmware control byte not written");

  a_addr_write_word: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == ncpo_pkg::ADDR_STATIC_ADDR && pstrb == 4'hf |=> static_addr == $past(pwdata))
    else $error("static address not written");

  a_mask_write_word: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == ncpo_pkg::ADDR_STATIC_MASK && pstrb == 4'hf |=> static_mask == $past(pwdata))
    else $error("static mask not written");

  // The remaining checks cover the capture of the dynamic methods, the read-only words, the control bytes and the masked network write.
  a_dhcp_flag_follows: assert property (@(posedge pclk) disable iff (!presetn)
    capture_pending |=> net_active.dhcp_enable == $past(net_cfg[ncpo_pkg::BIT_DHCP]))
    else $error("DHCP assignment enable wrong");

  a_dynamic_addr_zero: assert property (@(posedge pclk) disable iff (!presetn)
    capture_pending && !net_cfg[ncpo_pkg::BIT_STATIC] |=> net_active.address == ncpo_pkg::ZERO_WORD
      && net_active.mask == ncpo_pkg::ZERO_WORD)
    else $error("static address applied without static bit");

  a_valid_after_capture: assert property (@(posedge pclk) disable iff (!presetn)
    capture_pending |=> net_active_valid)
    else $error("active configuration not flagged valid");

  a_hw_addr_read_only: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == ncpo_pkg::ADDR_HW_ADDR_LO |=> hw_address == $past(hw_address_in))
    else $error("hardware address taken from bus");

  a_status_user_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == ncpo_pkg::ADDR_STAT_USER |=> status_user_program == $past(status_user_program_in))
    else $error("user status word taken from bus");

  a_user_ctrl_byte: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == ncpo_pkg::ADDR_PROG_CTRL && pstrb[2] |=> control_user_program == $past(pwdata[23:16]))
    else $error("user program control byte not written");

  a_ctrl_read_count: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && paddr == ncpo_pkg::ADDR_PROG_CTRL |-> prdata == {8'h00, control_user_program, control_firmware,
      ncpo_pkg::ENTRY_COUNT})
    else $error("program control read data wrong");

  a_cfg_write_masked: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == ncpo_pkg::ADDR_NET_CFG && pstrb == 4'hf
      |=> net_cfg == ($past(pwdata) & ncpo_pkg::NET_CFG_WMASK))
    else $error("network word write not masked");

endmodule
`default_nettype wire

// [net_config_program_objects_tb.sv]
// Self-checking bench for the program object and network configuration bank.
`timescale 1ns/1ps
`default_nettype none
module net_config_program_objects_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, valid, err;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, st_fw, st_user, rd;
  logic [3:0] pstrb;
  logic [47:0] hw;
  logic [7:0] c_fw, c_user;
  ncpo_pkg::ncpo_net_active_t act;
  logic [7:0] cfgs [4] = '{8'h01, 8'h0c, 8'h44, 8'h20};
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;

  ncpo_regs i_ncpo_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .status_firmware_in(st_fw), .status_user_program_in(st_user), .hw_address_in(hw),
    .control_firmware(c_fw), .control_user_program(c_user), .net_active(act), .net_active_valid(valid));
  ncpo_apb_host i_ncpo_apb_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  always #4 pclk = ~pclk;

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // --------------------------------------------------------------------
  // Shared helpers.
  // --------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [17:0] a, input logic [31:0] exp, input logic exp_err = 1'b0);
    i_ncpo_apb_host.xfer(1'b0, a, 32'h00000000, rd, err);
    chk($sformatf("read %h", a), exp, rd);
    chk($sformatf("pslverr %h", a), {31'h0, exp_err}, {31'h0, err});
  endtask

  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    i_ncpo_apb_host.xfer(1'b1, a, d, rd, err);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Scenarios.
  // --------------------------------------------------------------------
  // The reset word 0000006c enables DHCP, automatic assignment and both name services.
  task automatic t_defaults();
    rd_chk(ncpo_pkg::ADDR_PROG_CTRL, 32'h00000002);
    rd_chk(ncpo_pkg::ADDR_PROG_STAT, 32'h00000002);
    rd_chk(ncpo_pkg::ADDR_STAT_FW, 32'h00000000);
    rd_chk(ncpo_pkg::ADDR_STAT_USER, 32'h00000000);
    rd_chk(ncpo_pkg::ADDR_HW_ADDR_LO, 32'h00000000);
    rd_chk(ncpo_pkg::ADDR_HW_ADDR_HI, 32'h00000000);
    rd_chk(ncpo_pkg::ADDR_NET_CFG, 32'h0000006c);
    rd_chk(ncpo_pkg::ADDR_STATIC_ADDR, 32'hc0a80792);
    rd_chk(ncpo_pkg::ADDR_STATIC_MASK, 32'h0fffff00);
    rd_chk(ncpo_pkg::ADDR_ACTIVE, 32'h0000003e);
    chk("control bytes", 32'h00000000, {16'h0, c_fw, c_user});
  endtask

  task automatic t_access();
    wr(ncpo_pkg::ADDR_PROG_CTRL, 32'hffffffff);
    rd_chk(ncpo_pkg::ADDR_PROG_CTRL, 32'h00ffff02);
    chk("control bytes", 32'h0000ffff, {16'h0, c_fw, c_user});
    wr(ncpo_pkg::ADDR_PROG_STAT, 32'hffffffff);
    rd_chk(ncpo_pkg::ADDR_PROG_STAT, 32'h00000002);
    wr(ncpo_pkg::ADDR_STAT_FW, 32'hffffffff);
    rd_chk(ncpo_pkg::ADDR_STAT_FW, 32'h00000000);
    wr(ncpo_pkg::ADDR_STAT_USER, 32'hffffffff);
    rd_chk(ncpo_pkg::ADDR_STAT_USER, 32'h00000000);
    wr(ncpo_pkg::ADDR_HW_ADDR_LO, 32'hffffffff);
    rd_chk(ncpo_pkg::ADDR_HW_ADDR_LO, 32'h00000000);
    wr(ncpo_pkg::ADDR_NET_CFG, 32'hffffff93);
    rd_chk(ncpo_pkg::ADDR_NET_CFG, 32'h00000001);
    wr(ncpo_pkg::ADDR_STATIC_ADDR, 32'h0a0b0c0d);
    rd_chk(ncpo_pkg::ADDR_STATIC_ADDR, 32'h0a0b0c0d);
    wr(ncpo_pkg::ADDR_STATIC_MASK, 32'hffffff00);
    rd_chk(ncpo_pkg::ADDR_STATIC_MASK, 32'hffffff00);
    rd_chk(ncpo_pkg::ADDR_ACTIVE, 32'h0000003e);
  endtask

  // Only configurations without a static and dynamic clash are written.
  task automatic t_restart();
    logic [7:0] c;
    foreach (cfgs[i]) begin
      c = cfgs[i];
      wr(ncpo_pkg::ADDR_NET_CFG, {24'h0, c});
      wr(ncpo_pkg::ADDR_RESTART, 32'h00000001);
      repeat (2) @(posedge pclk);
      #1;
      chk("flags", {27'h0, c[0], c[2], c[3], c[5], c[6]}, {27'h0, act[68:64]});
      chk("address", c[0] ? 32'h0a0b0c0d : 32'h0, act.address);
      chk("mask", c[0] ? 32'hffffff00 : 32'h0, act.mask);
      rd_chk(ncpo_pkg::ADDR_ACTIVE, {26'h0, 1'b1, c[6], c[5], c[3], c[2], c[0]});
    end
  endtask

  task automatic t_status();
    st_fw <= 32'h12345678;
    st_user <= 32'h9abcdef0;
    hw <= 48'h0a1b2c3d4e5f;
    rd_chk(ncpo_pkg::ADDR_STAT_FW, 32'h12345678);
    rd_chk(ncpo_pkg::ADDR_STAT_USER, 32'h9abcdef0);
    rd_chk(ncpo_pkg::ADDR_HW_ADDR_LO, 32'h2c3d4e5f);
    rd_chk(ncpo_pkg::ADDR_HW_ADDR_HI, 32'h00000a1b);
    rd_chk(18'h00200, 32'h00000000, 1'b1);
  endtask

  task automatic t_midreset();
    @(posedge pclk);
    presetn <= 1'b0;
    st_fw <= 32'h0;
    st_user <= 32'h0;
    hw <= 48'h0;
    repeat (4) @(posedge pclk);
    chk("valid in reset", 32'h0, {31'h0, valid});
    presetn <= 1'b1;
    t_defaults();
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    st_fw = 32'h0;
    st_user = 32'h0;
    hw = 48'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_defaults();
    t_access();
    t_restart();
    t_status();
    t_midreset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
